//--- inc/adc_cfg_pkg.sv
// constants, field layouts and carriers of the converter configuration bank
// assumes one 25 MHz clock and an APB master with 32-bit data
// Notes on behaviour
// - bit 6 doubles output clock buffer drive
// - channel B bit 0 selects high-frequency mode
// - channel A bit 0 selects high-frequency mode
// - channel A converges to midcode plus pedestal
// - pedestal is six-bit signed, bits 7 to 2
// - channel B converges to midcode plus pedestal
// - each channel uses only its own pedestal
// - hold bit freezes the offset estimate
// - bits 5 to 2 set loop period
// - pedestal and hold act only with loop on
package adc_cfg_pkg;

   // ***********************************************************
   // register indices (byte address is four times the index)
   // ***********************************************************
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   localparam logic [IDX_W-1:0] IDX_POWER = 10'h045;
   localparam logic [IDX_W-1:0] IDX_HF_A = 10'h058;
   localparam logic [IDX_W-1:0] IDX_PED_A = 10'h0BF;
   localparam logic [IDX_W-1:0] IDX_PED_B = 10'h0C1;
   localparam logic [IDX_W-1:0] IDX_LOOP = 10'h0CF;
   localparam logic [IDX_W-1:0] IDX_HF_B = 10'h01A;
   localparam logic [IDX_W-1:0] IDX_LOOP_EN = 10'h0D0;
   localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0E0;

   // ***********************************************************
   // field positions and reset values
   // ***********************************************************
   localparam int PWR_SLEEP_BIT = 7;
   localparam int PWR_CLK_DRV_BIT = 6;
   localparam int PWR_DATA_DRV_BIT = 5;
   localparam int PWR_OFF_BIT = 2;
   localparam int HF_BIT = 0;
   localparam int PED_MSB = 7;
   localparam int PED_LSB = 2;
   localparam int HOLD_BIT = 7;
   localparam int PERIOD_MSB = 5;
   localparam int PERIOD_LSB = 2;
   localparam int LOOP_ON_BIT = 5;
   localparam int ST_RUN_BIT = 0;
   localparam int ST_SLEEP_BIT = 1;
   localparam int ST_WAKE_BIT = 2;
   localparam int ST_OFF_BIT = 3;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [31:0] RD_ZERO = 32'h00000000;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_MHZ = 25;
   localparam int WAKE_TIME_US = 50;
   localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
   localparam int WAKE_W = 11;
   localparam int CNT_W = 16;

   // ***********************************************************
   // carriers and states
   // ***********************************************************
   typedef struct packed {
      logic sleep;
      logic clk_drv;
      logic data_drv;
      logic off;
   } power_s;

   typedef struct packed {
      logic on;
      logic hold;
      logic [3:0] period;
   } loop_s;

   typedef struct packed {
      logic [5:0] ped;
      logic high_freq;
   } chan_s;

   typedef enum {PWR_RUN, PWR_SLEEP, PWR_WAKE, PWR_OFF} pwr_e;

endpackage

//--- hw/adc_power_pedestal_config_regs.sv
// configuration bank: power, buffer drive, high-frequency mode, offset loop
// assumes APB master on ref_clk and samples synchronous to ref_clk
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module adc_power_pedestal_config_regs
   import adc_cfg_pkg::*;
#(
   parameter int DATA_W = 14
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter samples
   input wire logic [DATA_W-1:0] ch_a_in,
   input wire logic [DATA_W-1:0] ch_b_in,
   output logic [DATA_W-1:0] ch_a_out,
   output logic [DATA_W-1:0] ch_b_out,
   // analog and buffer controls
   output logic both_channel_sleep,
   output logic clock_buffer_drive_double,
   output logic data_buffer_drive_double,
   output logic total_power_off,
   output logic chan_a_high_input_freq,
   output logic chan_b_high_input_freq,
   output logic conv_active
);

   // narrower words cannot hold midcode plus the pedestal range
   if (DATA_W < 8 || DATA_W > 16) begin : g_bad_width
      $error("DATA_W out of range");
   end

   localparam int SW = DATA_W + 2;
   localparam logic [DATA_W-1:0] MID = DATA_W'(1) << (DATA_W - 1);
   localparam logic [DATA_W-1:0] MAXC = '1;

   // ***********************************************************
   // register storage
   // ***********************************************************
   power_s power;
   loop_s loop;
   chan_s chan [2];
   pwr_e state;
   logic [WAKE_W-1:0] wake_cnt;
   logic [CNT_W-1:0] tick_cnt;
   logic tick;

   logic [IDX_W-1:0] idx;
   logic mapped;
   logic wr_en;
   logic [7:0] rd_byte;

   assign idx = paddr[ADDR_W-1:2];
   assign wr_en = psel && penable && pwrite && mapped;

   always_comb begin
      unique case (idx)
         IDX_POWER, IDX_HF_A, IDX_HF_B, IDX_PED_A, IDX_PED_B,
         IDX_LOOP, IDX_LOOP_EN, IDX_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // zero wait states: data prepared in setup, answered in access
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // only the defined bits are stored, so unused bits read as zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         power <= '0;
         loop <= '0;
         chan[0] <= '0;
         chan[1] <= '0;
      end else if (wr_en) begin
         unique case (idx)
            IDX_POWER: begin
               power.sleep <= pwdata[PWR_SLEEP_BIT];
               power.clk_drv <= pwdata[PWR_CLK_DRV_BIT];
               power.data_drv <= pwdata[PWR_DATA_DRV_BIT];
               power.off <= pwdata[PWR_OFF_BIT];
            end
            IDX_HF_A: chan[0].high_freq <= pwdata[HF_BIT];
            IDX_HF_B: chan[1].high_freq <= pwdata[HF_BIT];
            IDX_PED_A: chan[0].ped <= pwdata[PED_MSB:PED_LSB];
            IDX_PED_B: chan[1].ped <= pwdata[PED_MSB:PED_LSB];
            IDX_LOOP: begin
               loop.hold <= pwdata[HOLD_BIT];
               loop.period <= pwdata[PERIOD_MSB:PERIOD_LSB];
            end
            IDX_LOOP_EN: loop.on <= pwdata[LOOP_ON_BIT];
            default: ;
         endcase
      end
   end

   // ***********************************************************
   // read path
   // ***********************************************************
   always_comb begin
      rd_byte = REG_RESET;
      unique case (idx)
         IDX_POWER: begin
            rd_byte[PWR_SLEEP_BIT] = power.sleep;
            rd_byte[PWR_CLK_DRV_BIT] = power.clk_drv;
            rd_byte[PWR_DATA_DRV_BIT] = power.data_drv;
            rd_byte[PWR_OFF_BIT] = power.off;
         end
         IDX_HF_A: rd_byte[HF_BIT] = chan[0].high_freq;
         IDX_HF_B: rd_byte[HF_BIT] = chan[1].high_freq;
         IDX_PED_A: rd_byte[PED_MSB:PED_LSB] = chan[0].ped;
         IDX_PED_B: rd_byte[PED_MSB:PED_LSB] = chan[1].ped;
         IDX_LOOP: begin
            rd_byte[HOLD_BIT] = loop.hold;
            rd_byte[PERIOD_MSB:PERIOD_LSB] = loop.period;
         end
         IDX_LOOP_EN: rd_byte[LOOP_ON_BIT] = loop.on;
         IDX_STATUS: begin
            rd_byte[ST_RUN_BIT] = (state == PWR_RUN);
            rd_byte[ST_SLEEP_BIT] = (state == PWR_SLEEP);
            rd_byte[ST_WAKE_BIT] = (state == PWR_WAKE);
            rd_byte[ST_OFF_BIT] = (state == PWR_OFF);
         end
         default: ;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata <= RD_ZERO;
      end else if (psel && !penable) begin
         prdata <= {24'h000000, rd_byte};
      end
   end

   // ***********************************************************
   // power sequencing
   // ***********************************************************
   // wake time is the typical figure; a real part may need margin
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= PWR_RUN;
      end else begin
         unique case (state)
            PWR_RUN: begin
               if (power.off) state <= PWR_OFF;
               else if (power.sleep) state <= PWR_SLEEP;
            end
            PWR_SLEEP: begin
               if (power.off) state <= PWR_OFF;
               else if (!power.sleep) state <= PWR_WAKE;
            end
            PWR_WAKE: begin
               if (power.off) state <= PWR_OFF;
               else if (power.sleep) state <= PWR_SLEEP;
               else if (wake_cnt == WAKE_W'(WAKE_CYCLES - 1)) begin
                  state <= PWR_RUN;
               end
            end
            PWR_OFF: begin
               if (!power.off) begin
                  state <= power.sleep ? PWR_SLEEP : PWR_WAKE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake_cnt <= '0;
      end else if (state == PWR_WAKE) begin
         wake_cnt <= wake_cnt + WAKE_W'(1);
      end else begin
         wake_cnt <= '0;
      end
   end

   assign both_channel_sleep = power.sleep;
   assign clock_buffer_drive_double = power.clk_drv;
   assign data_buffer_drive_double = power.data_drv;
   assign total_power_off = power.off;
   assign chan_a_high_input_freq = chan[0].high_freq;
   assign chan_b_high_input_freq = chan[1].high_freq;
   assign conv_active = (state == PWR_RUN);

   // ***********************************************************
   // offset loop timebase
   // ***********************************************************
   logic [CNT_W-1:0] period_len;
   assign period_len = CNT_W'(1) << loop.period;
   assign tick = (tick_cnt >= period_len - CNT_W'(1));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= '0;
      end else if (tick || !loop.on) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + CNT_W'(1);
      end
   end

   // ***********************************************************
   // per-channel offset correction
   // ***********************************************************
   logic [DATA_W-1:0] samp [2];
   logic [DATA_W-1:0] outv [2];
   logic signed [SW-1:0] est [2];
   logic signed [SW-1:0] err [2];

   assign samp[0] = ch_a_in;
   assign samp[1] = ch_b_in;
   assign ch_a_out = outv[0];
   assign ch_b_out = outv[1];

   for (genvar i = 0; i < 2; i++) begin : g_chan
      logic signed [SW-1:0] corr;
      logic signed [SW-1:0] targ;

      assign corr = $signed({2'b00, samp[i]}) - est[i];
      // each channel reads its own pedestal only
      assign targ = $signed({2'b00, MID})
                    + SW'($signed(chan[i].ped));
      assign err[i] = corr - targ;

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            est[i] <= '0;
         end else if (!loop.on) begin
            est[i] <= '0;
         end else if (loop.hold) begin
            est[i] <= est[i];
         end else if (tick && state == PWR_RUN) begin
            // one-code steps: slow but free of limit cycles
            if (err[i] > 0) est[i] <= est[i] + SW'(1);
            else if (err[i] < 0) est[i] <= est[i] - SW'(1);
         end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            outv[i] <= '0;
         end else if (state != PWR_RUN) begin
            outv[i] <= '0;
         end else if (!loop.on) begin
            outv[i] <= samp[i];
         end else if (corr < 0) begin
            outv[i] <= '0;
         end else if (corr > $signed({2'b00, MAXC})) begin
            outv[i] <= MAXC;
         end else begin
            outv[i] <= corr[DATA_W-1:0];
         end
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence pwr_write_s;
      psel && penable && pwrite && idx == IDX_POWER;
   endsequence

   sequence wake_done_s;
      state == PWR_WAKE ##1 state == PWR_RUN;
   endsequence

   sleep_entry_a: assert property (
      state == PWR_RUN && power.sleep && !power.off |=> state == PWR_SLEEP)
      else $error("standby not entered");

   wake_time_a: assert property (
      wake_done_s |-> $past(wake_cnt) == WAKE_W'(WAKE_CYCLES - 1))
      else $error("wake time wrong");

   clk_drive_a: assert property (
      pwr_write_s
      |=> clock_buffer_drive_double == $past(pwdata[PWR_CLK_DRV_BIT]))
      else $error("clock drive not updated");

   hf_b_a: assert property (
      psel && penable && pwrite && idx == IDX_HF_B
      |=> chan_b_high_input_freq == $past(pwdata[HF_BIT]))
      else $error("channel B mode not updated");

   hf_a_a: assert property (
      psel && penable && pwrite && idx == IDX_HF_A
      |=> chan_a_high_input_freq == $past(pwdata[HF_BIT]))
      else $error("channel A mode not updated");

   off_quiet_a: assert property (
      power.off |=> ##1 ch_a_out == '0 && ch_b_out == '0)
      else $error("outputs active in power-off");

   loop_off_raw_a: assert property (
      !loop.on && state == PWR_RUN |=> ch_a_out == $past(ch_a_in))
      else $error("raw pass-through broken");

   hold_est_a: assert property (
      loop.on && loop.hold |=> $stable(est[0]) && $stable(est[1]))
      else $error("estimate moved while held");

   step_a_a: assert property (
      loop.on && !loop.hold && tick && state == PWR_RUN && err[0] > 0
      |=> est[0] == $past(est[0]) + SW'(1))
      else $error("channel A loop did not step");

   step_b_a: assert property (
      loop.on && !loop.hold && tick && state == PWR_RUN && err[1] < 0
      |=> est[1] == $past(est[1]) - SW'(1))
      else $error("channel B loop did not step");

   period_a: assert property (
      loop.on && loop.period == 4'h1 && tick && $stable(loop.period)
      |=> !tick ##1 tick)
      else $error("loop period wrong");

   ped_split_a: assert property (
      psel && penable && pwrite && idx == IDX_PED_A |=> $stable(chan[1].ped))
      else $error("channel B pedestal moved");

   raw_pass_b_a: assert property (
      !loop.on && state == PWR_RUN |=> ch_b_out == $past(ch_b_in))
      else $error("raw pass-through broken on B");

   sleep_quiet_a: assert property (
      state == PWR_SLEEP |=> ch_a_out == '0 && ch_b_out == '0)
      else $error("outputs active in standby");

   est_clear_a: assert property (
      !loop.on |=> est[0] == '0 && est[1] == '0)
      else $error("estimate kept with loop off");

endmodule // adc_power_pedestal_config_regs

//--- verification/adc_power_pedestal_config_regs_tb.sv
// self-checking bench for the converter configuration bank
// assumes zero or more APB wait states and a 25 MHz ref_clk
`timescale 1ns/10ps
module adc_power_pedestal_config_regs_tb
   import adc_cfg_pkg::*;
();
   // ***********************************************************
   // signals
   // ***********************************************************
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [13:0] ch_a_in, ch_b_in, ch_a_out, ch_b_out;
   logic both_channel_sleep, clock_buffer_drive_double;
   logic data_buffer_drive_double, total_power_off;
   logic chan_a_high_input_freq, chan_b_high_input_freq, conv_active;
   int num_errors = 0;
   int total_checks = 0;

   adc_power_pedestal_config_regs #(.DATA_W(14)) dut (
      .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ch_a_in(ch_a_in),
      .ch_b_in(ch_b_in), .ch_a_out(ch_a_out), .ch_b_out(ch_b_out),
      .both_channel_sleep(both_channel_sleep),
      .clock_buffer_drive_double(clock_buffer_drive_double),
      .data_buffer_drive_double(data_buffer_drive_double),
      .total_power_off(total_power_off),
      .chan_a_high_input_freq(chan_a_high_input_freq),
      .chan_b_high_input_freq(chan_b_high_input_freq),
      .conv_active(conv_active));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ***********************************************************
   // helpers
   // ***********************************************************
   task automatic chk_bit(input string name, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", name, e, g);
      end
   endtask

   task automatic chk_word(input string name, input logic [31:0] e,
                           input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 8'h00, r, e);
      chk_word("readback", {24'h000000, d}, r);
      chk_bit("read error", 1'b0, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic test_reset();
      logic [IDX_W-1:0] regs [7];
      regs = '{IDX_POWER, IDX_HF_A, IDX_HF_B, IDX_PED_A, IDX_PED_B,
               IDX_LOOP, IDX_LOOP_EN};
      foreach (regs[i]) rchk(regs[i], REG_RESET);
      chk_bit("active after reset", 1'b1, conv_active);
      $display("test reset done");
   endtask

   task automatic test_drive();
      wr(IDX_POWER, 8'h40);
      settle(2);
      chk_bit("clock drive", 1'b1, clock_buffer_drive_double);
      chk_bit("data drive", 1'b0, data_buffer_drive_double);
      rchk(IDX_POWER, 8'h40);
      wr(IDX_POWER, 8'h20);
      settle(2);
      chk_bit("clock drive", 1'b0, clock_buffer_drive_double);
      chk_bit("data drive", 1'b1, data_buffer_drive_double);
      wr(IDX_POWER, 8'h00);
      $display("test drive done");
   endtask

   task automatic test_high_freq();
      wr(IDX_HF_A, 8'h01);
      settle(2);
      chk_bit("hf a", 1'b1, chan_a_high_input_freq);
      chk_bit("hf b", 1'b0, chan_b_high_input_freq);
      wr(IDX_HF_B, 8'h01);
      wr(IDX_HF_A, 8'h00);
      settle(2);
      chk_bit("hf a", 1'b0, chan_a_high_input_freq);
      chk_bit("hf b", 1'b1, chan_b_high_input_freq);
      rchk(IDX_HF_B, 8'h01);
      wr(IDX_HF_B, 8'h00);
      $display("test high_freq done");
   endtask

   // midcode 2000h; inputs sit 20 codes above it
   task automatic test_pedestal();
      ch_a_in <= 14'h2014;
      ch_b_in <= 14'h2014;
      wr(IDX_PED_A, 8'h14);
      wr(IDX_PED_B, 8'hF4);
      wr(IDX_LOOP, 8'h00);
      wr(IDX_LOOP_EN, 8'h20);
      settle(100);
      chk_word("ped a +5", 32'h2005, {18'h0, ch_a_out});
      chk_word("ped b -3", 32'h1FFD, {18'h0, ch_b_out});
      wr(IDX_PED_A, 8'h80);
      settle(100);
      chk_word("ped a -32", 32'h1FE0, {18'h0, ch_a_out});
      chk_word("ped b kept", 32'h1FFD, {18'h0, ch_b_out});
      wr(IDX_LOOP, 8'h80);
      ch_a_in <= 14'h201E;
      settle(50);
      chk_word("held estimate", 32'h1FEA, {18'h0, ch_a_out});
      wr(IDX_LOOP, 8'h10);
      settle(40);
      chk_bit("slow loop", 1'b1, ch_a_out > 14'h1FE3);
      settle(200);
      chk_word("slow converged", 32'h1FE0, {18'h0, ch_a_out});
      // raising the B target makes its estimate step downwards
      wr(IDX_PED_B, 8'h14);
      settle(200);
      chk_word("ped b +5", 32'h2005, {18'h0, ch_b_out});
      chk_word("ped a kept", 32'h1FE0, {18'h0, ch_a_out});
      wr(IDX_LOOP_EN, 8'h00);
      settle(2);
      chk_word("loop off raw", 32'h201E, {18'h0, ch_a_out});
      chk_word("loop off raw b", 32'h2014, {18'h0, ch_b_out});
      // fast loop left running so the period check sees ticks
      wr(IDX_LOOP, 8'h04);
      wr(IDX_LOOP_EN, 8'h20);
      $display("test pedestal done");
   endtask

   // enters a low-power setting, then counts the wake-up cycles
   task automatic test_power(input logic [7:0] v);
      int n;
      wr(IDX_POWER, v);
      settle(3);
      chk_bit("sleep out", v[7], both_channel_sleep);
      chk_bit("off out", v[2], total_power_off);
      chk_bit("inactive", 1'b0, conv_active);
      chk_word("quiet a", 32'h0, {18'h0, ch_a_out});
      chk_word("quiet b", 32'h0, {18'h0, ch_b_out});
      rchk(IDX_STATUS, 8'h01 << (v[7] ? ST_SLEEP_BIT : ST_OFF_BIT));
      wr(IDX_POWER, 8'h00);
      n = 0;
      // one cycle to leave the low-power state, then the wake count
      while (conv_active !== 1'b1 && n < 2 * WAKE_CYCLES) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk_word("wake cycles", WAKE_CYCLES + 1, n);
      rchk(IDX_STATUS, 8'h01 << ST_RUN_BIT);
      $display("test power %h done", v);
   endtask

   task automatic test_unmapped();
      logic [31:0] r;
      logic e;
      apb(1'b1, 10'h3FF, 8'h5A, r, e);
      chk_bit("unmapped write error", 1'b1, e);
      apb(1'b0, 10'h3FF, 8'h00, r, e);
      chk_bit("unmapped read error", 1'b1, e);
      chk_word("unmapped data", RD_ZERO, r);
      $display("test unmapped done");
   endtask

   // ***********************************************************
   // sequence and verdict
   // ***********************************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      ch_a_in = 14'h2000;
      ch_b_in = 14'h2000;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      test_reset();
      test_drive();
      test_high_freq();
      test_pedestal();
      test_power(8'h80);
      test_power(8'h04);
      test_unmapped();
      stop_test();
   end

   // whole run needs about 3300 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      stop_test();
   end
endmodule // adc_power_pedestal_config_regs_tb
